// ===== hw/eac_area_cfg.v
// external area decode, per-area configuration and select strobe generation
//
// Contract
// - eight areas, each configured independently
// - area select low during its access
// - rom off: area0 pin out, others in
// - rom on: all in until enabled
// - shared pin asserts for any routed area
// - per-area settings; internal accesses fixed
// - four interface types, basic after reset
// - page rom areas 0-1, mux 3-7
// - per-area 8 or 16 bit width
// - byte sram forces 16 bit
// - width reset from latched mode
// - bus mode 16 if any area 16
// - little order bits areas 7-2, reset big
// - basic areas two or three state
// - waits only in three-state areas
// - cycles: base, waits, extension, external
// - select extension per area by register
// - byte sram uses same cycle composition
// - areas 0-1 type from two bits
`default_nettype none
`include "eac_consts.vh"

module eac_area_cfg (
  input  wire        mclk,           // system clock
  input  wire        rst,            // synchronous reset, high
  input  wire        ce,             // clock enable, freezes state low
  input  wire        mode_rom_en,    // strap: internal rom enabled
  input  wire        mode_bus16,     // strap: 16-bit initial width
  input  wire [5:0]  reg_addr,       // register byte address
  input  wire [31:0] reg_wdata,      // register write data
  input  wire        reg_wr,         // register write strobe
  input  wire        reg_rd,         // register read strobe
  output reg  [31:0] reg_rdata_ff,   // read data, cycle after strobe
  input  wire        acc_req,        // access request pulse
  input  wire [23:0] acc_addr,       // access address
  input  wire        acc_internal,   // access hits on-chip space
  input  wire        wait_n,         // external wait request pin, low
  output reg         acc_busy_ff,    // access in progress
  output reg         acc_done_ff,    // access finished pulse
  output reg         acc_width16_ff, // current access is 16 bit
  output reg         acc_little_ff,  // current access little order
  output reg  [1:0]  acc_iftype_ff,  // current interface type
  output reg         bus16_mode_ff,  // 16-bit bus mode
  output reg  [7:0]  area_select_n_ff, // select pin levels, low
  output reg  [7:0]  select_oe_n_ff    // select pin drive, low drives
);

  // configuration registers; all are plain read-write except the read-only rom strap and
  // where masks keep unused wait bits and the bits of areas that cannot use a function at zero
  reg  [7:0]  pin_function_ctrl_ff; // pin drive enables
  reg  [7:0]  area_width_ctrl_ff;   // 1 = 16 bit
  reg  [7:0]  byte_order_ctrl_ff;   // 1 = little order
  reg  [7:0]  access_state_ctrl_ff; // 1 = three state
  reg  [15:0] prog_wait_ctrl_a_ff;  // waits areas 0-3
  reg  [15:0] prog_wait_ctrl_b_ff;  // waits areas 4-7
  reg  [15:0] select_extend_ctrl_ff; // lead low byte, trail high
  reg  [7:0]  byte_sram_ctrl_ff;    // byte sram choice
  reg  [7:0]  page_rom_ctrl_ff;     // page rom choice
  reg  [7:0]  muxed_io_ctrl_ff;     // muxed io choice
  reg  [23:0] pin_route_ctrl_ff;    // 3-bit pin per area
  reg         rom_en_ff;            // latched rom strap

  // access sequencer
  // one access at a time; the strobe pins are formed from its state
  reg  [2:0]  state_ff;        // access state
  reg  [2:0]  nxt_state;       // next access state
  reg  [2:0]  area_ff;         // area being accessed
  reg  [2:0]  wcnt_ff;         // programmed wait counter
  reg  [2:0]  nxt_wcnt;        // next wait count
  reg         three_ff;        // latched three-state choice
  reg         trail_ff;        // latched trailing extension
  reg  [2:0]  pwait_ff;        // latched programmed waits
  reg         done_now;        // access finishing now

  // wait pin synchroniser and filter
  reg         wait_s1_ff;      // first stage
  reg         wait_s2_ff;      // second stage
  reg         wait_s3_ff;      // third stage
  reg         wait_req_ff;     // accepted wait request

  // decoded request configuration
  wire [2:0]  req_area = acc_addr[`EAC_AREA_MSB:`EAC_AREA_LSB];
  reg  [1:0]  req_if;          // resolved interface type
  reg  [2:0]  req_pw;          // programmed waits of area
  reg  [7:0]  nxt_sel_n;       // next pin levels
  reg  [2:0]  sel_area;        // area whose strobe is formed
  integer     p;               // pin loop index
  integer     a;               // area loop index

  // resolve interface type of an area; the page rom and mux bits are masked
  // to the areas that may use them, so only the refused page rom plus
  // byte sram pair needs care here: it falls back to the basic cycle, which
  // every device can follow, instead of an undefined mix of the two
  function [1:0] eac_iftype;
    input [2:0] ar;
    input [7:0] bs;
    input [7:0] pr;
    input [7:0] mx;
    begin
      eac_iftype = `EAC_IF_BASIC;
      if (pr[ar] && bs[ar])
        eac_iftype = `EAC_IF_BASIC; // prohibited pair falls back
      else if (pr[ar])
        eac_iftype = `EAC_IF_PROM;
      else if (mx[ar])
        eac_iftype = `EAC_IF_MUX;
      else if (bs[ar])
        eac_iftype = `EAC_IF_BSRAM;
    end
  endfunction

  // combinational decode of the requested area; it looks at the address
  // that stands beside the request, so it is only meaningful in idle
  // wait fields are four bits apart with the top bit of each unused
  always @* begin
    req_if = eac_iftype(req_area, byte_sram_ctrl_ff,
                        page_rom_ctrl_ff, muxed_io_ctrl_ff);
    if (req_area[2])
      req_pw = prog_wait_ctrl_b_ff[{req_area[1:0], 2'h0} +: 3];
    else
      req_pw = prog_wait_ctrl_a_ff[{req_area[1:0], 2'h0} +: 3];
  end

  // wait pin passes three flops, accepted when last two agree
  // the pin comes from outside the clock domain: the first flop may go
  // metastable, so only the second and third are looked at, and a level
  // that does not stand for two cycles never reaches the sequencer
  // the idle level is high, so reset loads ones to avoid a false request
  always @(posedge mclk) begin
    if (rst) begin
      wait_s1_ff  <= 1'b1;
      wait_s2_ff  <= 1'b1;
      wait_s3_ff  <= 1'b1;
      wait_req_ff <= 1'b0;
    end else if (ce) begin
      wait_s1_ff <= wait_n;
      wait_s2_ff <= wait_s1_ff;
      wait_s3_ff <= wait_s2_ff;
      if (wait_s2_ff == wait_s3_ff)
        wait_req_ff <= ~wait_s3_ff;
    end
  end

  // register writes; straps caught while reset is held
  // the straps are read on every reset edge, so a mode change made while
  // reset stands takes effect on release without a second reset
  // masks keep bits of areas that cannot use a type at zero, so a read
  // shows what the hardware will really do
  always @(posedge mclk) begin
    if (rst) begin
      rom_en_ff <= mode_rom_en;
      if (mode_rom_en)
        pin_function_ctrl_ff <= `EAC_RST_PIN_ROMEN;
      else
        pin_function_ctrl_ff <= `EAC_RST_PIN_ROMDIS;
      area_width_ctrl_ff    <= {8{mode_bus16}};
      byte_order_ctrl_ff    <= `EAC_RST_ZERO8;
      access_state_ctrl_ff  <= `EAC_RST_ZERO8;
      prog_wait_ctrl_a_ff   <= 16'h0000;
      prog_wait_ctrl_b_ff   <= 16'h0000;
      select_extend_ctrl_ff <= 16'h0000;
      byte_sram_ctrl_ff     <= `EAC_RST_ZERO8;
      page_rom_ctrl_ff      <= `EAC_RST_ZERO8;
      muxed_io_ctrl_ff      <= `EAC_RST_ZERO8;
      pin_route_ctrl_ff     <= `EAC_RST_ROUTE;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `EAC_OFS_PIN_FUNC: pin_function_ctrl_ff <= reg_wdata[7:0];
        `EAC_OFS_WIDTH:    area_width_ctrl_ff   <= reg_wdata[7:0];
        `EAC_OFS_ORDER:
          byte_order_ctrl_ff <= reg_wdata[7:0] & `EAC_MASK_ORDER;
        `EAC_OFS_ASTATE:   access_state_ctrl_ff <= reg_wdata[7:0];
        `EAC_OFS_WAIT_A:   prog_wait_ctrl_a_ff  <= reg_wdata[15:0] & 16'h7777;
        `EAC_OFS_WAIT_B:   prog_wait_ctrl_b_ff  <= reg_wdata[15:0] & 16'h7777;
        `EAC_OFS_SEL_EXT:  select_extend_ctrl_ff <= reg_wdata[15:0];
        `EAC_OFS_BSRAM:    byte_sram_ctrl_ff    <= reg_wdata[7:0];
        `EAC_OFS_PROM:
          page_rom_ctrl_ff <= reg_wdata[7:0] & `EAC_MASK_PROM;
        `EAC_OFS_MUX:
          muxed_io_ctrl_ff <= reg_wdata[7:0] & `EAC_MASK_MUX;
        `EAC_OFS_ROUTE:    pin_route_ctrl_ff    <= reg_wdata[23:0];
        default: ; // unmapped or read-only: ignored
      endcase
    end
  end

  // read data stands in the cycle after the strobe only
  // the bus is cleared in every cycle without a read so a master that looks late
  // sees zero rather than stale data; reads have no side effects
  // status shows the latched mode and the sequencer for debug
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (ce) begin
      reg_rdata_ff <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `EAC_OFS_PIN_FUNC: reg_rdata_ff[7:0]  <= pin_function_ctrl_ff;
          `EAC_OFS_WIDTH:    reg_rdata_ff[7:0]  <= area_width_ctrl_ff;
          `EAC_OFS_ORDER:    reg_rdata_ff[7:0]  <= byte_order_ctrl_ff;
          `EAC_OFS_ASTATE:   reg_rdata_ff[7:0]  <= access_state_ctrl_ff;
          `EAC_OFS_WAIT_A:   reg_rdata_ff[15:0] <= prog_wait_ctrl_a_ff;
          `EAC_OFS_WAIT_B:   reg_rdata_ff[15:0] <= prog_wait_ctrl_b_ff;
          `EAC_OFS_SEL_EXT:  reg_rdata_ff[15:0] <= select_extend_ctrl_ff;
          `EAC_OFS_BSRAM:    reg_rdata_ff[7:0]  <= byte_sram_ctrl_ff;
          `EAC_OFS_PROM:     reg_rdata_ff[7:0]  <= page_rom_ctrl_ff;
          `EAC_OFS_MUX:      reg_rdata_ff[7:0]  <= muxed_io_ctrl_ff;
          `EAC_OFS_ROUTE:    reg_rdata_ff[23:0] <= pin_route_ctrl_ff;
          `EAC_OFS_STATUS:
            reg_rdata_ff[9:0] <= {rom_en_ff, bus16_mode_ff, acc_busy_ff,
                                  area_ff, 1'b0, state_ff};
          default: reg_rdata_ff <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // next state of the access sequencer
  // order of states: optional lead extension, first and second state,
  // then for three-state areas the programmed waits, the pin waits and
  // the third state, and at last the optional trailing extension
  // the done pulse is raised in the cycle after the last state, when the
  // strobes are already back high
  // two-state areas never look at the wait pin or the wait counter
  always @* begin
    nxt_state = state_ff;
    nxt_wcnt  = wcnt_ff;
    done_now  = 1'b0;
    case (state_ff)
      `EAC_ST_IDLE: begin
        if (acc_req && !acc_internal) begin
          if (select_extend_ctrl_ff[req_area])
            nxt_state = `EAC_ST_HOLD;
          else
            nxt_state = `EAC_ST_T1;
        end
      end
      `EAC_ST_HOLD: nxt_state = `EAC_ST_T1; // lead extension
      `EAC_ST_T1:   nxt_state = `EAC_ST_T2;
      `EAC_ST_T2: begin
        if (!three_ff) begin
          // two-state areas never wait
          if (trail_ff)
            nxt_state = `EAC_ST_TAIL;
          else
            done_now = 1'b1;
        end else if (pwait_ff != 3'h0) begin
          nxt_state = `EAC_ST_PW;
          nxt_wcnt  = pwait_ff - 3'h1;
        end else if (wait_req_ff) begin
          nxt_state = `EAC_ST_EW;
        end else begin
          nxt_state = `EAC_ST_T3;
        end
      end
      `EAC_ST_PW: begin
        if (wcnt_ff != 3'h0)
          nxt_wcnt = wcnt_ff - 3'h1; // programmed waits
        else if (wait_req_ff)
          nxt_state = `EAC_ST_EW;
        else
          nxt_state = `EAC_ST_T3;
      end
      `EAC_ST_EW: begin
        if (!wait_req_ff)
          nxt_state = `EAC_ST_T3; // wait sampled every cycle
      end
      `EAC_ST_T3: begin
        if (trail_ff)
          nxt_state = `EAC_ST_TAIL;
        else
          done_now = 1'b1;
      end
      `EAC_ST_TAIL: done_now = 1'b1; // trailing extension
      default: nxt_state = `EAC_ST_IDLE;
    endcase
    if (done_now)
      nxt_state = `EAC_ST_IDLE;
  end

  // sequencer registers and per-access latched settings
  // settings are latched when the request is taken, so a register write
  // during an access cannot change its timing or width half way through
  // a request while busy is not taken and gives no sign of it
  always @(posedge mclk) begin
    if (rst) begin
      state_ff       <= `EAC_ST_IDLE;
      wcnt_ff        <= 3'h0;
      area_ff        <= 3'h0;
      three_ff       <= 1'b0;
      trail_ff       <= 1'b0;
      pwait_ff       <= 3'h0;
      acc_busy_ff    <= 1'b0;
      acc_done_ff    <= 1'b0;
      acc_width16_ff <= 1'b0;
      acc_little_ff  <= 1'b0;
      acc_iftype_ff  <= `EAC_IF_BASIC;
    end else if (ce) begin
      state_ff    <= nxt_state;
      wcnt_ff     <= nxt_wcnt;
      acc_done_ff <= done_now;
      acc_busy_ff <= (nxt_state != `EAC_ST_IDLE);
      if (state_ff == `EAC_ST_IDLE && acc_req) begin
        if (acc_internal) begin
          // on-chip access: fixed one-cycle, fixed width
          acc_done_ff    <= 1'b1;
          acc_width16_ff <= 1'b1;
          acc_little_ff  <= 1'b0;
          acc_iftype_ff  <= `EAC_IF_BASIC;
        end else begin
          area_ff       <= req_area;
          acc_iftype_ff <= req_if;
          three_ff      <= access_state_ctrl_ff[req_area];
          trail_ff      <= select_extend_ctrl_ff[{1'b1, req_area}];
          pwait_ff      <= req_pw;
          if (req_if == `EAC_IF_BSRAM)
            acc_width16_ff <= 1'b1;
          else
            acc_width16_ff <= area_width_ctrl_ff[req_area];
          acc_little_ff <= byte_order_ctrl_ff[req_area];
        end
      end
    end
  end

  // merge area strobes onto routed pins
  // a request taken in idle has not yet loaded area_ff, so the requested
  // area is used there; otherwise the first state would run without its
  // strobe and a device could miss the start of the access
  // several areas may be routed to one pin: any of them pulls it low
  always @* begin
    nxt_sel_n = 8'hff;
    if (state_ff == `EAC_ST_IDLE)
      sel_area = req_area; // request being taken now
    else
      sel_area = area_ff;  // access already latched
    for (p = 0; p < 8; p = p + 1) begin
      for (a = 0; a < 8; a = a + 1) begin
        if (nxt_state != `EAC_ST_IDLE && sel_area == a[2:0] &&
            pin_route_ctrl_ff[a*3 +: 3] == p[2:0])
          nxt_sel_n[p] = 1'b0;
      end
    end
  end

  // pin drive and bus mode registers
  // the drive enables follow the pin function bits one cycle late; the
  // strobe levels are formed even for undriven pins, which simply do
  // not show them
  always @(posedge mclk) begin
    if (rst) begin
      area_select_n_ff <= 8'hff;
      // drive enables match the pin function reset value from the first
      // reset edge on
      if (mode_rom_en)
        select_oe_n_ff <= ~`EAC_RST_PIN_ROMEN; // rom on: all inputs
      else
        select_oe_n_ff <= ~`EAC_RST_PIN_ROMDIS; // rom off: area 0 drives
      bus16_mode_ff    <= 1'b0;
    end else if (ce) begin
      // strobes follow the next state, so they open with the lead extension or the first state
      // and close as the done pulse rises
      area_select_n_ff <= nxt_sel_n;
      select_oe_n_ff <= ~pin_function_ctrl_ff;
      bus16_mode_ff  <= |area_width_ctrl_ff;
    end
  end

endmodule // eac_area_cfg
`default_nettype wire

// ===== hw/eac_consts.vh
// constants for the external area select and configuration block
`ifndef EAC_CONSTS_VH
`define EAC_CONSTS_VH
// register byte offsets on the plain register port
`define EAC_OFS_PIN_FUNC   6'h00
`define EAC_OFS_WIDTH      6'h04
`define EAC_OFS_ORDER      6'h08
`define EAC_OFS_ASTATE     6'h0c
`define EAC_OFS_WAIT_A     6'h10
`define EAC_OFS_WAIT_B     6'h14
`define EAC_OFS_SEL_EXT    6'h18
`define EAC_OFS_BSRAM      6'h1c
`define EAC_OFS_PROM       6'h20
`define EAC_OFS_MUX        6'h24
`define EAC_OFS_ROUTE      6'h28
`define EAC_OFS_STATUS     6'h2c
// reset values
`define EAC_RST_PIN_ROMDIS 8'h01
`define EAC_RST_PIN_ROMEN  8'h00
`define EAC_RST_ROUTE      24'hfac688
`define EAC_RST_ZERO8      8'h00
// writable masks for area-limited fields
`define EAC_MASK_ORDER     8'hfc
`define EAC_MASK_PROM      8'h03
`define EAC_MASK_MUX       8'hf8
// interface type codes
`define EAC_IF_BASIC       2'h0
`define EAC_IF_BSRAM       2'h1
`define EAC_IF_PROM        2'h2
`define EAC_IF_MUX         2'h3
// address field that names the area
`define EAC_AREA_MSB       23
`define EAC_AREA_LSB       21
// access state codes
`define EAC_ST_IDLE        3'h0
`define EAC_ST_HOLD        3'h1
`define EAC_ST_T1          3'h2
`define EAC_ST_T2          3'h3
`define EAC_ST_PW          3'h4
`define EAC_ST_EW          3'h5
`define EAC_ST_T3          3'h6
`define EAC_ST_TAIL        3'h7
`endif

// ===== testbench/eac_area_cfg_assertions.sv
// concurrent checks on the ports of the external area block
`default_nettype none
module eac_area_cfg_chk (
  input wire logic        mclk,             // system clock
  input wire logic        rst,              // synchronous reset, high
  input wire logic        mode_rom_en,      // rom strap
  input wire logic        reg_rd,           // read strobe
  input wire logic [31:0] reg_rdata_ff,     // read data
  input wire logic        acc_req,          // access request
  input wire logic        acc_internal,     // on-chip access
  input wire logic        acc_busy_ff,      // access in progress
  input wire logic        acc_done_ff,      // access end pulse
  input wire logic        acc_width16_ff,   // access width
  input wire logic [7:0]  area_select_n_ff, // select pins, low
  input wire logic [7:0]  select_oe_n_ff    // pin drive, low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_oe_after_reset: assert property ($fell(rst) |->
    select_oe_n_ff == (mode_rom_en ? 8'hff : 8'hfe)) else $error("pin drive after reset");
  a_select_in_access: assert property (area_select_n_ff != 8'hff |-> acc_busy_ff)
    else $error("select low when idle");
  a_busy_select: assert property (acc_busy_ff |-> area_select_n_ff != 8'hff)
    else $error("busy without select");
  a_single_pin_low: assert property ($onehot0(~area_select_n_ff))
    else $error("two pins low");
  a_start_select: assert property (acc_req && !acc_busy_ff && !acc_internal |=>
    acc_busy_ff && area_select_n_ff != 8'hff) else $error("access did not start");
  a_internal_fixed: assert property (acc_req && !acc_busy_ff && acc_internal |=>
    acc_done_ff && acc_width16_ff && area_select_n_ff == 8'hff) else $error("internal");
  a_done_ends_busy: assert property ($fell(acc_busy_ff) |-> acc_done_ff)
    else $error("busy fell without done");
  a_done_idle: assert property (acc_done_ff |-> !acc_busy_ff && area_select_n_ff == 8'hff)
    else $error("done during access");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
    else $error("read data without read");
  a_access_bounded: assert property (acc_busy_ff |-> ##[0:40] !acc_busy_ff)
    else $error("access too long");
endmodule // eac_area_cfg_chk
bind eac_area_cfg eac_area_cfg_chk u_chk (.mclk(mclk), .rst(rst), .mode_rom_en(mode_rom_en),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .acc_req(acc_req),
  .acc_internal(acc_internal), .acc_busy_ff(acc_busy_ff), .acc_done_ff(acc_done_ff),
  .acc_width16_ff(acc_width16_ff), .area_select_n_ff(area_select_n_ff),
  .select_oe_n_ff(select_oe_n_ff));
`default_nettype wire

// ===== testbench/eac_ext_dev.sv
// external device model that stretches accesses through the wait pin
`default_nettype none
module eac_ext_dev (
  input  wire logic       mclk,   // system clock
  input  wire logic [7:0] sel_n,  // select pin levels, low
  input  wire logic [3:0] stall,  // wait cycles asked, 0 answers at once
  output var  logic       wait_n  // wait request, low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] prev_n = 8'hff; // pin levels one cycle ago
  int         cnt = 0;        // wait cycles still held
  initial wait_n = 1'b1;
  // a select going low starts a stall; released line returns to pull-up
  always @(posedge mclk) begin
    prev_n <= sel_n;
    if (prev_n == 8'hff && sel_n != 8'hff && stall != 4'h0) begin
      cnt <= stall;
      wait_n <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      wait_n <= 1'b1;
    end
  end
endmodule // eac_ext_dev
`default_nettype wire

// ===== testbench/external_area_select_config_tb.sv
// self-checking bench for the external area select block
`default_nettype none
`include "eac_consts.vh"
module external_area_select_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [23:0] a; logic in; int st; logic [3:0] at;} eac_row_t;
  logic        mclk = 1'b0, rst = 1'b1, rom_en = 1'b0, bus16 = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, req = 1'b0, intl = 1'b0, ce = 1'b1;
  logic [5:0]  ra = 6'h0;
  logic [31:0] wd = 32'h0;
  logic [23:0] aa = 24'h0;
  logic [3:0]  stall = 4'h0;
  logic [31:0] rdata;
  logic        busy, done, w16, le, b16;
  logic [1:0]  ift;
  logic [7:0]  sel_n, oe_n;
  wire         wait_n;
  int          fails = 0, tests_run = 0, cyc = 0, last_n = 0;
  // accesses after setup: address, internal, states, {width16, little, type}
  eac_row_t rows [9] = '{'{24'h000010, 1'b0, 2, 4'h8}, '{24'h200000, 1'b0, 2, 4'h2},
    '{24'h400000, 1'b0, 2, 4'h4}, '{24'h600000, 1'b0, 10, 4'h0},
    '{24'h800000, 1'b0, 2, 4'h9}, '{24'ha00000, 1'b0, 4, 4'hc},
    '{24'hc00000, 1'b0, 4, 4'h0}, '{24'he00000, 1'b0, 2, 4'h3},
    '{24'h600004, 1'b1, 0, 4'h8}};
  logic [5:0]  ro [8] = '{`EAC_OFS_PIN_FUNC, `EAC_OFS_WIDTH, `EAC_OFS_ORDER, `EAC_OFS_ASTATE,
    `EAC_OFS_BSRAM, `EAC_OFS_PROM, `EAC_OFS_MUX, `EAC_OFS_ROUTE};
  logic [31:0] rv [8] = '{32'h1, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hfac688};
  logic [5:0]  co [10] = '{`EAC_OFS_PIN_FUNC, `EAC_OFS_WIDTH, `EAC_OFS_ORDER, `EAC_OFS_ASTATE,
    `EAC_OFS_WAIT_A, `EAC_OFS_WAIT_B, `EAC_OFS_SEL_EXT, `EAC_OFS_BSRAM, `EAC_OFS_PROM,
    `EAC_OFS_MUX};
  logic [31:0] cd [10] = '{32'hff, 32'h21, 32'h24, 32'h28, 32'h7000, 32'h3010, 32'h4040,
    32'h11, 32'h3, 32'h80};

  always #12.5 mclk = ~mclk;

  eac_area_cfg DUT (.mclk(mclk), .rst(rst), .ce(ce), .mode_rom_en(rom_en),
    .mode_bus16(bus16), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_ff(rdata), .acc_req(req), .acc_addr(aa), .acc_internal(intl),
    .wait_n(wait_n), .acc_busy_ff(busy), .acc_done_ff(done), .acc_width16_ff(w16),
    .acc_little_ff(le), .acc_iftype_ff(ift), .bus16_mode_ff(b16),
    .area_select_n_ff(sel_n), .select_oe_n_ff(oe_n));

  eac_ext_dev u_dev (.mclk(mclk), .sel_n(sel_n), .stall(stall), .wait_n(wait_n));

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [5:0] a, input logic [31:0] exp, input string s);
    @(posedge mclk);
    ra <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp, s);
  endtask

  // one access: cycles to done, pins and attributes in the first cycle
  task automatic acc(input logic [23:0] a, input logic in, input int st,
                     input logic [7:0] pins, input logic [3:0] at, input string s);
    logic [7:0] p;
    logic [3:0] t;
    logic       b;
    @(posedge mclk);
    aa <= a;
    intl <= in;
    req <= 1'b1;
    last_n = 0;
    do begin
      @(posedge mclk);
      req <= 1'b0;
      #1 last_n++;
      if (last_n == 1) begin
        p = sel_n;
        t = {w16, le, ift};
        b = busy;
      end
    end while (done !== 1'b1 && last_n < 60);
    if (st >= 0) chk(last_n, st + 1, s);
    chk(p, pins, s);
    chk(t, at, s);
    chk(b, !in, s);
    $display("test %s done", s);
  endtask

  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(oe_n, 8'hfe, "oe rom off");
    foreach (ro[i]) rreg(ro[i], rv[i], "reset");
    chk(b16, 1'b1, "bus16");
    wreg(`EAC_OFS_ORDER, 32'hff);
    rreg(`EAC_OFS_ORDER, 32'hfc, "order mask");
    wreg(`EAC_OFS_PROM, 32'hff);
    rreg(`EAC_OFS_PROM, 32'h3, "rom mask");
    wreg(`EAC_OFS_MUX, 32'hff);
    rreg(`EAC_OFS_MUX, 32'hf8, "mux mask");
    rreg(6'h30, 32'h0, "unmapped");
    foreach (co[i]) wreg(co[i], cd[i]);
    foreach (rows[i]) acc(rows[i].a, rows[i].in, rows[i].st, rows[i].in ? 8'hff :
      ~(8'h01 << rows[i].a[23:21]), rows[i].at, "row");
    wreg(`EAC_OFS_WIDTH, 32'h0);
    repeat (2) @(posedge mclk);
    #1 chk(b16, 1'b0, "bus8");
    wreg(`EAC_OFS_ORDER, 32'h0);
    wreg(`EAC_OFS_ROUTE, 32'hfac608);
    acc(24'h400000, 1'b0, 2, 8'hfe, 4'h0, "shared pin");
    stall <= 4'h6;
    acc(24'h600000, 1'b0, -1, 8'hf7, 4'h0, "ext wait");
    chk(last_n > 11 && last_n < 22, 1'b1, "ext wait");
    repeat (12) @(posedge mclk);
    acc(24'h000000, 1'b0, 2, 8'hfe, 4'h0, "two state");
    stall <= 4'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b1;
    rom_en <= 1'b1;
    bus16 <= 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(oe_n, 8'hff, "oe rom on");
    rreg(`EAC_OFS_WIDTH, 32'h0, "width strap");
    rreg(`EAC_OFS_STATUS, 32'h200, "status");
    @(posedge mclk);
    ce <= 1'b0;
    wreg(`EAC_OFS_WAIT_A, 32'h1);
    ce <= 1'b1;
    rreg(`EAC_OFS_WAIT_A, 32'h0, "ce hold");
    wreg(`EAC_OFS_PIN_FUNC, 32'h8);
    repeat (2) @(posedge mclk);
    #1 chk(oe_n, 8'hf7, "oe enable");
    $display("test reset modes done");
    final_report();
  end
endmodule // external_area_select_config_tb
`default_nettype wire
